// ### sdram_ref_pkg.sv
package sdram_ref_pkg;

  // Mode-register write windows, offset X lands on the SDRAM address lines
  localparam logic [31:0] MODE_WIN_AREA2 = 32'ha4fd_4000;
  localparam logic [31:0] MODE_WIN_AREA3 = 32'ha4fd_5000;
  localparam logic [31:0] MODE_WIN_MASK = 32'hffff_f000;
  localparam int MODE_VAL_W = 12;

  // Register block, word aligned
  localparam logic [31:0] REG_BASE = 32'ha4fd_3000;
  localparam logic [31:0] REG_MASK = 32'hffff_ffe0;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_TIMING = 5'h04;
  localparam logic [4:0] OFS_RCOUNT = 5'h08;
  localparam logic [4:0] OFS_RCONST = 5'h0c;
  localparam logic [4:0] OFS_STATUS = 5'h10;

  // Control fields
  localparam int CTRL_REN_BIT = 0;
  localparam int CTRL_RMS_BIT = 1;
  localparam int CTRL_LOWF_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;

  // Timing fields
  localparam int TIM_TRP_LSB = 0;
  localparam int TIM_TRC_LSB = 4;
  localparam logic [1:0] TRP_RST = 2'h3;
  localparam logic [1:0] TRC_RST = 2'h3;

  // Status fields
  localparam int STAT_SELF_BIT = 0;
  localparam int STAT_INIT_BIT = 1;
  localparam int STAT_PEND_BIT = 2;
  localparam int STAT_GRANT_BIT = 3;
  localparam int STAT_LOST_BIT = 4;

  localparam logic [3:0] INIT_REF_COUNT = 4'h8;

  // Mode values, burst length 1: single write / burst write, bus width, latency
  localparam logic [11:0] MODE_SW_16_CL2 = 12'h440;
  localparam logic [11:0] MODE_SW_16_CL3 = 12'h460;
  localparam logic [11:0] MODE_SW_32_CL2 = 12'h880;
  localparam logic [11:0] MODE_SW_32_CL3 = 12'h8c0;
  localparam logic [11:0] MODE_BW_16_CL2 = 12'h040;
  localparam logic [11:0] MODE_BW_16_CL3 = 12'h060;
  localparam logic [11:0] MODE_BW_32_CL2 = 12'h080;
  localparam logic [11:0] MODE_BW_32_CL3 = 12'h0c0;

  typedef struct packed {
    logic cke;
    logic cs2_n;
    logic cs3_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sdram_cmd_s;

  localparam sdram_cmd_s CMD_NOP = 6'b1_00_111;
  localparam sdram_cmd_s CMD_PRE_ALL = 6'b1_00_010;
  localparam sdram_cmd_s CMD_REF = 6'b1_00_001;
  localparam sdram_cmd_s CMD_SELF = 6'b0_00_001;
  localparam sdram_cmd_s CMD_MRS2 = 6'b1_01_000;
  localparam sdram_cmd_s CMD_MRS3 = 6'b1_10_000;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_TRP = 6'b000010,
    ST_TRC = 6'b000100,
    ST_SELF = 6'b001000,
    ST_MRSI = 6'b010000,
    ST_SPARE = 6'b100000
  } seq_state_e;

endpackage

// ### sdram_refresh_ctrl.sv
// Notes on behaviour
// R1: Setting both mode-select and enable bits starts self-refresh.
// R2: Self-refresh entry: precharge-all, precharge idle count, then self-refresh command.
// R3: No SDRAM access is allowed while in self-refresh.
// R4: Clearing mode-select leaves self-refresh; commands blocked for recovery count.
// R5: Enable set and mode-select clear at exit resumes periodic auto-refresh.
// R6: Software preloads the counter one below the constant for early refresh.
// R7: Self-refresh survives standby and any recovery except power-on reset.
// R8: Power-on reset initialises all registers and ends self-refresh.
// R9: Refresh waits for bus cycle end and for bus ownership to return.
// R10: A new refresh request while one pends replaces it; one pending only.
// R11: External bus request during self-refresh is not granted until it ends.
// R12: Low-frequency mode launches commands, address, write data on falling edge.
// R13: Low-frequency mode captures read data on the rising edge.
// R14: Byte write to window base plus X issues mode-register write with X.
// R15: Mode write is byte-size; written data is ignored.
// R16: Address bits 12 and up are zero during a mode-register write.
// R17: Single-write mode values are 440, 460, 880 or 8c0 hexadecimal.
// R18: Burst-write mode values are 040, 060, 080 or 0c0 hexadecimal.
// R19: Initialisation: one precharge-all, eight auto-refreshes, one mode-register set.
// R20: Spacing: idle count, recovery count, and one idle after mode set.
// R21: Software programs configuration registers before the mode-register write.
// R22: Software waits the SDRAM power-up idle time before initialisation.
// R23: Counter matches constant: refresh request, clear to zero, keep counting.
// R24: Auto-refresh runs when mode-select is clear and enable is set.
// R25: Self-refresh entry waits until any bus cycle in progress completes.
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sdram_refresh_ctrl
  import sdram_ref_pkg::*;
#(
  parameter int CNT_W = 8,
  parameter int ADDR_W = 15,
  parameter int DQ_W = 32
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Avalon-MM register slave
  input wire logic [31:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Bus side
  input wire logic i_cyc_busy,
  input wire logic i_ext_breq,
  output logic o_bus_grant,
  output logic o_acc_ok,
  // SDRAM pins
  input wire logic i_bus_clk,
  input wire logic [DQ_W-1:0] i_sdram_dq,
  output sdram_cmd_s o_sdram_cmd,
  output logic [ADDR_W-1:0] o_sdram_addr,
  output logic [DQ_W-1:0] o_rd_data
);

  seq_state_e st_ff;
  logic [2:0] ctrl_ff;
  logic [1:0] trp_ff, trc_ff;
  logic [CNT_W-1:0] rcnt_ff, rconst_ff;
  logic pend_ff, lost_ff, grant_ff, sr_flag_ff, init_ff, init_req_ff, rd_done_ff;
  logic [2:0] bclk_sync_ff;
  logic [1:0] breq_sync_ff;
  logic [DQ_W-1:0] dq_s1_ff, dq_s2_ff;
  logic [1:0] cnt_ff;
  logic [3:0] ref_n_ff;
  logic [MODE_VAL_W-1:0] mode_val_ff;
  logic mode_area3_ff;
  sdram_cmd_s cmd_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [31:0] rdata_ff;

  function automatic logic [1:0] lane_of(input logic [3:0] be);
    lane_of = be[3] ? 2'h3 : be[2] ? 2'h2 : be[1] ? 2'h1 : 2'h0;
  endfunction

  function automatic logic one_hot4(input logic [3:0] be);
    one_hot4 = (be != 4'h0) && ((be & (be - 4'h1)) == 4'h0);
  endfunction

  // Link clock and pins: two flops before any logic reads them
  always_ff @(posedge i_sys_clk) begin
    bclk_sync_ff <= {bclk_sync_ff[1:0], i_bus_clk};
    breq_sync_ff <= {breq_sync_ff[0], i_ext_breq};
    dq_s1_ff <= i_sdram_dq;
    dq_s2_ff <= dq_s1_ff;
  end

  logic bclk_rise, bclk_fall, lowf, slot, cap_edge, breq;
  assign bclk_rise = bclk_sync_ff[1] & ~bclk_sync_ff[2];
  assign bclk_fall = ~bclk_sync_ff[1] & bclk_sync_ff[2];
  assign lowf = ctrl_ff[CTRL_LOWF_BIT];
  assign slot = lowf ? bclk_fall : bclk_rise; // [R12]
  assign cap_edge = lowf ? bclk_rise : bclk_fall; // [R13]
  assign breq = breq_sync_ff[1];

  // Bus decode
  logic reg_hit, win2_hit, win3_hit, win_hit, mode_take;
  logic [4:0] reg_ofs;
  assign reg_hit = (i_avs_address & REG_MASK) == REG_BASE;
  assign reg_ofs = i_avs_address[4:0];
  assign win2_hit = (i_avs_address & MODE_WIN_MASK) == MODE_WIN_AREA2;
  assign win3_hit = (i_avs_address & MODE_WIN_MASK) == MODE_WIN_AREA3;
  assign win_hit = win2_hit | win3_hit;
  // Mode writes stall while an initialisation sequence is queued or running
  assign mode_take = i_avs_write & win_hit & ~init_req_ff & ~init_ff;

  always_comb begin
    if (i_avs_read) begin
      o_avs_waitrequest = ~rd_done_ff;
    end else if (i_avs_write & win_hit) begin
      o_avs_waitrequest = ~mode_take;
    end else begin
      o_avs_waitrequest = 1'b0;
    end
  end
  assign o_avs_readdata = rdata_ff;

  logic reg_wr;
  assign reg_wr = i_avs_write & reg_hit;

  // Power-on reset is the only reset; standby never touches these [R7] [R8]
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ctrl_ff <= CTRL_RST;
      trp_ff <= TRP_RST;
      trc_ff <= TRC_RST;
      rconst_ff <= '0;
    end else if (reg_wr && i_avs_byteenable[0]) begin
      if (reg_ofs == OFS_CTRL) begin
        ctrl_ff <= i_avs_writedata[2:0];
      end
      if (reg_ofs == OFS_TIMING) begin
        trp_ff <= i_avs_writedata[TIM_TRP_LSB +: 2];
        trc_ff <= i_avs_writedata[TIM_TRC_LSB +: 2];
      end
      if (reg_ofs == OFS_RCONST) begin
        rconst_ff <= i_avs_writedata[CNT_W-1:0];
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rd_done_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      rd_done_ff <= i_avs_read & ~rd_done_ff;
      if (i_avs_read & ~rd_done_ff) begin
        rdata_ff <= '0;
        if (reg_hit) begin
          unique case (reg_ofs)
            OFS_CTRL: rdata_ff[2:0] <= ctrl_ff;
            OFS_TIMING: rdata_ff <= 32'({trc_ff, 2'h0, trp_ff});
            OFS_RCOUNT: rdata_ff[CNT_W-1:0] <= rcnt_ff;
            OFS_RCONST: rdata_ff[CNT_W-1:0] <= rconst_ff;
            OFS_STATUS: rdata_ff[4:0] <= {lost_ff, grant_ff, pend_ff, init_ff,
                                          st_ff == ST_SELF};
            default: rdata_ff <= '0;
          endcase
        end
      end
    end
  end

  // Mode write: data ignored, only single-byte writes start a sequence
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      init_req_ff <= 1'b0;
      mode_val_ff <= '0;
      mode_area3_ff <= 1'b0;
    end else if (mode_take && one_hot4(i_avs_byteenable)) begin // [R14] [R15]
      init_req_ff <= 1'b1;
      mode_val_ff <= {i_avs_address[MODE_VAL_W-1:2], lane_of(i_avs_byteenable)}; // [R17] [R18]
      mode_area3_ff <= win3_hit;
    end else if (slot && st_ff == ST_IDLE && init_req_ff && !i_cyc_busy && !grant_ff) begin
      init_req_ff <= 1'b0;
    end
  end

  // Refresh counter ticks on rising bus clock edges only
  logic auto_en, match;
  assign auto_en = ctrl_ff[CTRL_REN_BIT] & ~ctrl_ff[CTRL_RMS_BIT]; // [R24] [R5]
  assign match = auto_en && bclk_rise && (rcnt_ff == rconst_ff);

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rcnt_ff <= '0;
    end else if (reg_wr && i_avs_byteenable[0] && reg_ofs == OFS_RCOUNT) begin
      rcnt_ff <= i_avs_writedata[CNT_W-1:0]; // [R6]
    end else if (match) begin
      rcnt_ff <= '0; // [R23]
    end else if (auto_en && bclk_rise) begin
      rcnt_ff <= rcnt_ff + CNT_W'(1);
    end
  end

  logic start_ok, take_ref;
  assign start_ok = slot && st_ff == ST_IDLE && !i_cyc_busy && !grant_ff; // [R9] [R25]
  assign take_ref = start_ok && !init_req_ff && pend_ff && auto_en;

  // Single pending flag; a repeat match overwrites it, set beats take
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pend_ff <= 1'b0;
      lost_ff <= 1'b0;
    end else begin
      if (match) begin
        pend_ff <= 1'b1; // [R10] [R23]
      end else if (take_ref || !auto_en) begin
        pend_ff <= 1'b0;
      end
      if (match && pend_ff && !take_ref) begin
        lost_ff <= 1'b1; // [R10]
      end
    end
  end

  // Bus release only from idle, never during self-refresh or a sequence
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      grant_ff <= 1'b0;
    end else if (!breq) begin
      grant_ff <= 1'b0;
    end else if (st_ff == ST_IDLE && !i_cyc_busy && !init_req_ff && !pend_ff &&
                 !ctrl_ff[CTRL_RMS_BIT]) begin
      grant_ff <= 1'b1; // [R11]
    end
  end
  assign o_bus_grant = grant_ff;

  assign o_acc_ok = st_ff == ST_IDLE && cmd_ff.cke && !grant_ff; // [R3]

  // Command sequencer, advances only on launch edges
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_ff <= ST_IDLE;
      cmd_ff <= CMD_NOP;
      addr_ff <= '0;
      cnt_ff <= '0;
      ref_n_ff <= '0;
      sr_flag_ff <= 1'b0;
      init_ff <= 1'b0;
    end else if (slot) begin
      cmd_ff <= st_ff == ST_SELF ? CMD_SELF : CMD_NOP;
      unique case (st_ff)
        ST_IDLE: begin
          if (start_ok && (init_req_ff || ctrl_ff[CTRL_RMS_BIT] || take_ref)) begin
            cmd_ff <= CMD_PRE_ALL; // [R2] [R19]
            cnt_ff <= trp_ff;
            st_ff <= ST_TRP;
            init_ff <= init_req_ff;
            sr_flag_ff <= !init_req_ff && ctrl_ff[CTRL_RMS_BIT] &&
                          ctrl_ff[CTRL_REN_BIT]; // [R1]
            ref_n_ff <= '0;
          end
        end
        ST_TRP: begin
          if (cnt_ff != 2'h0) begin
            cnt_ff <= cnt_ff - 2'h1; // [R20]
          end else if (sr_flag_ff) begin
            cmd_ff <= CMD_SELF; // [R2]
            st_ff <= ST_SELF;
          end else begin
            cmd_ff <= CMD_REF;
            ref_n_ff <= ref_n_ff + 4'h1;
            cnt_ff <= trc_ff;
            st_ff <= ST_TRC;
          end
        end
        ST_TRC: begin
          if (cnt_ff != 2'h0) begin
            cnt_ff <= cnt_ff - 2'h1; // [R4] [R20]
          end else if (init_ff && ref_n_ff != INIT_REF_COUNT) begin
            cmd_ff <= CMD_REF; // [R19]
            ref_n_ff <= ref_n_ff + 4'h1;
            cnt_ff <= trc_ff;
          end else if (init_ff) begin
            cmd_ff <= mode_area3_ff ? CMD_MRS3 : CMD_MRS2; // [R19]
            addr_ff <= ADDR_W'(mode_val_ff); // [R16]
            st_ff <= ST_MRSI;
          end else begin
            st_ff <= ST_IDLE;
          end
        end
        ST_SELF: begin
          if (!ctrl_ff[CTRL_RMS_BIT]) begin
            cmd_ff <= CMD_NOP; // [R4]
            cnt_ff <= trc_ff;
            sr_flag_ff <= 1'b0;
            st_ff <= ST_TRC;
          end
        end
        ST_MRSI: begin
          addr_ff <= '0;
          init_ff <= 1'b0;
          st_ff <= ST_IDLE; // [R20]
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end
  assign o_sdram_cmd = cmd_ff;
  assign o_sdram_addr = addr_ff;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rd_data <= '0;
    end else if (cap_edge) begin
      o_rd_data <= dq_s2_ff; // [R13]
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence self_leave_s;
    st_ff == ST_SELF && slot && !ctrl_ff[CTRL_RMS_BIT];
  endsequence
  sequence recover_s;
    st_ff == ST_TRC && cnt_ff == $past(trc_ff) && !init_ff;
  endsequence

  self_entry_a: assert property ( // [R1]
    (st_ff != ST_SELF ##1 st_ff == ST_SELF) |->
      ctrl_ff[CTRL_RMS_BIT] && ctrl_ff[CTRL_REN_BIT])
    else $error("self-refresh entered without both bits set");
  no_access_self_a: assert property ( // [R3]
    st_ff == ST_SELF |-> !o_acc_ok && !o_sdram_cmd.cke)
    else $error("access allowed during self-refresh");
  sr_exit_a: assert property ( // [R4]
    self_leave_s |=> recover_s)
    else $error("self-refresh exit without recovery wait");
  count_up_a: assert property ( // [R24]
    auto_en && bclk_rise && !match && !reg_wr |=> rcnt_ff == $past(rcnt_ff) + CNT_W'(1))
    else $error("refresh counter did not advance");
  hold_busy_a: assert property ( // [R9]
    st_ff == ST_IDLE && (i_cyc_busy || grant_ff) |=> st_ff == ST_IDLE)
    else $error("refresh started during bus cycle or release");
  match_clear_a: assert property ( // [R23]
    match && !reg_wr |=> rcnt_ff == '0 && pend_ff)
    else $error("match did not clear counter and raise request");
  grant_block_a: assert property ( // [R11]
    $rose(grant_ff) |-> $past(st_ff) == ST_IDLE && !$past(ctrl_ff[CTRL_RMS_BIT]))
    else $error("bus granted outside idle");
  mrs_addr_a: assert property ( // [R16]
    !cmd_ff.ras_n && !cmd_ff.cas_n && !cmd_ff.we_n |->
      o_sdram_addr[ADDR_W-1:MODE_VAL_W] == '0 && ref_n_ff == INIT_REF_COUNT)
    else $error("mode write with high address bits or wrong refresh count");
  launch_edge_a: assert property ( // [R12]
    $changed(cmd_ff) |-> $past(slot))
    else $error("command changed off launch edge");
  mrs_idle_a: assert property ( // [R20]
    st_ff == ST_MRSI && slot |=> cmd_ff == CMD_NOP && st_ff == ST_IDLE)
    else $error("no idle slot after mode set");

endmodule
`default_nettype wire

// ### sdram_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdram_model
  import sdram_ref_pkg::*;
#(
  parameter int ADDR_W = 15,
  parameter int DQ_W = 32
) (
  // Controller pins
  input wire logic i_sys_clk,
  input wire logic i_bus_clk,
  input wire sdram_cmd_s i_cmd,
  input wire logic [ADDR_W-1:0] i_addr,
  // Read data pins
  output logic [DQ_W-1:0] o_dq,
  // Observation
  output logic [7:0] o_n_prech,
  output logic [7:0] o_n_ref,
  output logic [7:0] o_n_self,
  output logic [7:0] o_n_mrs,
  output logic [ADDR_W-1:0] o_mrs_addr,
  output sdram_cmd_s o_mrs_cmd,
  output logic o_clk_lvl
);
  sdram_cmd_s prev_ff;
  initial begin
    prev_ff = CMD_NOP;
    o_n_prech = 8'h00;
    o_n_ref = 8'h00;
    o_n_self = 8'h00;
    o_n_mrs = 8'h00;
  end
  // Data follows the clock level, so a capture on the wrong edge reads the inverse
  always_comb o_dq = i_bus_clk ? {(DQ_W/2){2'b10}} : {(DQ_W/2){2'b01}};
  // Level of the bus clock when a command appears tells which edge launched it
  always @(i_cmd) begin
    if (i_cmd !== CMD_NOP) o_clk_lvl = i_bus_clk;
  end
  always @(posedge i_sys_clk) begin
    prev_ff <= i_cmd;
    if (i_cmd !== prev_ff) begin
      if (i_cmd === CMD_PRE_ALL) o_n_prech <= o_n_prech + 8'h01;
      if (i_cmd === CMD_REF) o_n_ref <= o_n_ref + 8'h01;
      if (i_cmd === CMD_SELF) o_n_self <= o_n_self + 8'h01;
      if (i_cmd === CMD_MRS2 || i_cmd === CMD_MRS3) begin
        o_n_mrs <= o_n_mrs + 8'h01;
        o_mrs_addr <= i_addr;
        o_mrs_cmd <= i_cmd;
      end
    end
  end
endmodule
`default_nettype wire

// ### sdram_refresh_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sdram_refresh_ctrl_tb
  import sdram_ref_pkg::*;
();
  localparam logic [31:0] A_CTRL = REG_BASE | {27'h0, OFS_CTRL};
  localparam logic [31:0] A_TIM = REG_BASE | {27'h0, OFS_TIMING};
  localparam logic [31:0] A_CNT = REG_BASE | {27'h0, OFS_RCOUNT};
  localparam logic [31:0] A_CON = REG_BASE | {27'h0, OFS_RCONST};
  localparam logic [31:0] A_STAT = REG_BASE | {27'h0, OFS_STATUS};
  logic clk, rst, bus_clk, av_rd, av_wr, busy, breq, waitreq, grant, acc_ok, lvl;
  logic [31:0] av_addr, av_wdata, rd_w, rdata, dq, rd_cap;
  logic [3:0] av_be;
  logic [14:0] sd_addr, mrs_addr;
  sdram_cmd_s cmd, mrs_cmd;
  logic [7:0] n_prech, n_ref, n_self, n_mrs, c0, c1, c2;
  logic [11:0] modes [8];
  int n_fail, compares;

  sdram_refresh_ctrl DUT (
    .i_sys_clk(clk), .i_rst(rst),
    .i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
    .i_avs_writedata(av_wdata), .i_avs_byteenable(av_be),
    .o_avs_readdata(rd_w), .o_avs_waitrequest(waitreq),
    .i_cyc_busy(busy), .i_ext_breq(breq), .o_bus_grant(grant), .o_acc_ok(acc_ok),
    .i_bus_clk(bus_clk), .i_sdram_dq(dq), .o_sdram_cmd(cmd),
    .o_sdram_addr(sd_addr), .o_rd_data(rd_cap)
  );
  sdram_model mem (
    .i_sys_clk(clk), .i_bus_clk(bus_clk), .i_cmd(cmd), .i_addr(sd_addr), .o_dq(dq),
    .o_n_prech(n_prech), .o_n_ref(n_ref), .o_n_self(n_self), .o_n_mrs(n_mrs),
    .o_mrs_addr(mrs_addr), .o_mrs_cmd(mrs_cmd), .o_clk_lvl(lvl)
  );

  task automatic close_out();
    $display("Compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Mode writes can stall for a whole sequence, hence the long bound
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int k;
    k = 0;
    @(posedge clk);
    av_addr <= a;
    av_wdata <= d;
    av_be <= be;
    av_wr <= w;
    av_rd <= !w;
    do begin
      @(posedge clk);
      k++;
    end while (waitreq !== 1'b0 && k < 9000);
    rdata = rd_w;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    if (k >= 9000) begin
      n_fail++;
      $display("Error bus wait expected 0 seen %b", waitreq);
      close_out();
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task automatic rd(input logic [31:0] a);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask
  task automatic wait_new(input int w, input logic [7:0] base);
    int k;
    k = 0;
    while ((w == 0 ? n_ref : (w == 1 ? n_self : n_mrs)) === base && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 3000) begin
      n_fail++;
      $display("Error event wait expected change seen %0d", base);
      close_out();
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Link clock, eight system clock periods, edges 1 ns before a system clock rising edge
  initial begin
    bus_clk = 1'b0;
    #5;
    forever #16 bus_clk = ~bus_clk;
  end
  initial begin
    modes = '{MODE_SW_16_CL2, MODE_SW_16_CL3, MODE_SW_32_CL2, MODE_SW_32_CL3,
              MODE_BW_16_CL2, MODE_BW_16_CL3, MODE_BW_32_CL2, MODE_BW_32_CL3};
    n_fail = 0;
    compares = 0;
    {rst, av_rd, av_wr, busy, breq} = 5'b10000;
    av_addr = 32'h0;
    av_wdata = 32'h0;
    av_be = 4'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(A_TIM);
    chk("timing reset", {26'h0, TRC_RST, 2'h0, TRP_RST}, rdata);
    rd(A_CTRL);
    chk("ctrl reset", 32'h0, rdata);
    wr(REG_BASE | 32'h14, 32'hffff_ffff);
    rd(REG_BASE | 32'h14);
    chk("unmapped", 32'h0, rdata);
    $display("Test reset done");
    wr(A_TIM, 32'h21);
    for (int i = 0; i < 8; i++) begin
      c0 = n_prech;
      c1 = n_ref;
      c2 = n_mrs;
      bus(1'b1, (i % 2 ? MODE_WIN_AREA3 : MODE_WIN_AREA2) | {20'h0, modes[i]},
          32'h5a5a_5a5a, 4'h1);
      wait_new(2, c2);
      chk("precharge count", 32'(c0 + 8'h1), 32'(n_prech));
      chk("ref count", 32'(c1 + 8'h8), 32'(n_ref));
      chk("mode addr", {20'h0, modes[i]}, 32'(mrs_addr));
      chk("mode area", 32'(i % 2 ? CMD_MRS3 : CMD_MRS2), 32'(mrs_cmd));
    end
    c0 = n_prech;
    bus(1'b1, MODE_WIN_AREA2 | 32'h440, 32'h0, 4'h3);
    repeat (300) @(posedge clk);
    chk("halfword mode", 32'(c0), 32'(n_prech));
    $display("Test init done");
    wr(A_CON, 32'd40);
    wr(A_CNT, 32'd39);
    c1 = n_ref;
    wr(A_CTRL, 32'h1);
    wait_new(0, c1);
    chk("normal edge", 32'h1, 32'(lvl));
    chk("capture normal", 32'h5555_5555, rd_cap);
    rd(A_CNT);
    chk("count cleared", 32'h1, 32'(rdata < 32'd40));
    busy <= 1'b1;
    wr(A_CNT, 32'd39);
    c1 = n_ref;
    repeat (800) @(posedge clk);
    chk("ref in cycle", 32'(c1), 32'(n_ref));
    rd(A_STAT);
    chk("pend lost", 32'h14, rdata & 32'h14);
    busy <= 1'b0;
    wait_new(0, c1);
    repeat (20) @(posedge clk);
    chk("one ref", 32'(c1 + 8'h1), 32'(n_ref));
    breq <= 1'b1;
    repeat (20) @(posedge clk);
    chk("grant", 32'h1, 32'(grant));
    rd(A_STAT);
    chk("grant status", 32'h8, rdata & 32'h8);
    wr(A_CNT, 32'd39);
    c1 = n_ref;
    repeat (100) @(posedge clk);
    chk("ref granted", 32'(c1), 32'(n_ref));
    breq <= 1'b0;
    wait_new(0, c1);
    $display("Test auto refresh done");
    wr(A_CTRL, 32'h5);
    c1 = n_ref;
    wr(A_CNT, 32'd39);
    wait_new(0, c1);
    chk("low freq edge", 32'h0, 32'(lvl));
    chk("capture low freq", 32'haaaa_aaaa, rd_cap);
    $display("Test low frequency done");
    busy <= 1'b1;
    c0 = n_prech;
    c2 = n_self;
    wr(A_CTRL, 32'h3);
    repeat (100) @(posedge clk);
    chk("self in cycle", 32'(c2), 32'(n_self));
    busy <= 1'b0;
    wait_new(1, c2);
    chk("precharge first", 32'(c0 + 8'h1), 32'(n_prech));
    chk("cke low", 32'h0, 32'(cmd.cke));
    chk("no access", 32'h0, 32'(acc_ok));
    breq <= 1'b1;
    repeat (100) @(posedge clk);
    chk("grant in self", 32'h0, 32'(grant));
    breq <= 1'b0;
    wr(A_CNT, 32'd39);
    c1 = n_ref;
    wr(A_CTRL, 32'h1);
    wait_new(0, c1);
    chk("cke high", 32'h1, 32'(cmd.cke));
    c2 = n_self;
    wr(A_CTRL, 32'h3);
    wait_new(1, c2);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk("cke reset", 32'h1, 32'(cmd.cke));
    chk("access idle", 32'h1, 32'(acc_ok));
    rd(A_STAT);
    chk("self cleared", 32'h0, 32'(rdata[STAT_SELF_BIT]));
    $display("Test self refresh done");
    close_out();
  end
endmodule
`default_nettype wire
